// >>> pkg/sarc_pkg.sv
// shared constants for the converter control block
package sarc_pkg;
  // ************************************************************
  // code format
  // ************************************************************
  localparam int          CODE_W      = 14;
  localparam int          CODE_STEPS  = 16384;  // one step = vref / 16384
  localparam logic [13:0] CODE_FULL   = 14'h3FFF;
  localparam logic [13:0] CODE_MID    = 14'h2000;
  localparam logic [13:0] CODE_ZERO   = 14'h0000;
  localparam logic [13:0] CODE_ABORT  = 14'h3F80;  // first frame after abort
  localparam logic [13:0] CODE_MSB    = 14'h2000;

  // ************************************************************
  // frame edge counts
  // ************************************************************
  localparam logic [4:0] NAP_EXIT_RISE = 5'h08;  // leave nap on this rise
  localparam logic [4:0] SAMPLE_RISE   = 5'h09;  // switch closes here
  localparam logic [4:0] LAST_BIT_RISE = 5'h0E;  // shifts of data stop before this rise
  localparam logic [4:0] CONV_FALL     = 5'h10;  // conversion starts here
  localparam logic [2:0] INIT_CONVS    = 3'h4;   // discarded conversions

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_NS      = 100;
  localparam int PD_HOLD_NS  = 2000;  // powerdown_hold_threshold
  localparam int PD_WAKE_NS  = 3000;  // powerdown_wake_delay
  // least time: round up
  localparam int PD_HOLD_CYC = (PD_HOLD_NS + CLK_NS - 1) / CLK_NS;
  // longest time: round down, at least one cycle
  localparam int PD_WAKE_CYC = (PD_WAKE_NS / CLK_NS) < 1 ? 1
                               : (PD_WAKE_NS / CLK_NS);
  localparam logic [11:0] PD_HOLD_CNT = 12'(PD_HOLD_CYC);
  localparam logic [11:0] PD_WAKE_CNT = 12'(PD_WAKE_CYC);

  // ************************************************************
  // frame states
  // ************************************************************
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_DATA   = 4'b0010,
    ST_SAMPLE = 4'b0100,
    ST_CONV   = 4'b1000
  } sarc_state_e;
endpackage : sarc_pkg

// >>> logic/sarc_approx.sv
// successive approximation engine, one bit decided per clock
`timescale 1ns/1ps
`default_nettype none
module sarc_approx
  import sarc_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_rst_n,
  input  wire logic              i_ce,
  input  wire logic              i_start,
  input  wire logic              i_abort,
  input  wire logic [CODE_W-1:0] i_held,
  output logic                   o_done,
  output logic [CODE_W-1:0]      o_result
);
  logic [CODE_W-1:0] held_r;
  logic [CODE_W-1:0] trial_bit_r;
  logic [CODE_W-1:0] acc_r;
  logic              run_r;
  logic              done_r;
  wire  [CODE_W-1:0] trial_w = acc_r | trial_bit_r;
  wire               keep_w  = held_r >= trial_w;

  // binary search against the held sample; inputs are not read while
  // running, only the copy taken at start (see RULE12)
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      held_r      <= CODE_ZERO;
      trial_bit_r <= CODE_ZERO;
      acc_r       <= CODE_ZERO;
      run_r       <= 1'b0;
      done_r      <= 1'b0;
    end else if (i_ce) begin
      done_r <= 1'b0;
      if (i_abort) begin
        run_r <= 1'b0;
      end else if (i_start) begin
        held_r      <= i_held;  // see RULE12
        trial_bit_r <= CODE_MSB;
        acc_r       <= CODE_ZERO;
        run_r       <= 1'b1;
      end else if (run_r) begin
        if (keep_w) begin
          acc_r <= trial_w;
        end
        trial_bit_r <= trial_bit_r >> 1;
        if (trial_bit_r[0]) begin
          run_r  <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  assign o_done   = done_r;
  assign o_result = acc_r;  // straight binary code (see RULE1)
endmodule : sarc_approx
`default_nettype wire

// >>> logic/sarc_ctrl.sv
// frame, nap and powerdown/reset control of the serial converter
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1 - results are unsigned straight binary 14-bit codes, 3FFF full scale.
// RULE2 - one code step is the reference divided by 16384.
// RULE3 - powerdown_reset_n is active low and acts without any clock.
// RULE4 - reset abandons a running conversion at once.
// RULE5 - serial data output is released while in reset.
// RULE6 - short reset: normal operation resumes as soon as input rises.
// RULE7 - first four conversions after reset or powerdown are flagged invalid.
// RULE8 - low longer than powerdown_hold_threshold enters powerdown.
// RULE9 - after powerdown, ready again within powerdown_wake_delay; host waits. o_ready rises about 34 clocks (3400 ns) after the input rises.
// RULE10 - nap starts at every end of conversion, as busy falls.
// RULE11 - nap ends on the eighth serial clock rise of the next frame.
// RULE12 - input difference captured at conversion start, inputs isolated after.
// RULE13 - chip-select or frame-sync framing; busy high during conversion.
// RULE14 - nap to 8th rise, sample from 9th rise, convert on 16th fall.
// RULE15 - reset phase after input falls, output three-stated meanwhile.
module sarc_ctrl
  import sarc_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_resetn,
  input  wire logic              i_ce,
  input  wire logic              i_powerdown_reset_n,
  input  wire logic              i_cs_n,
  input  wire logic              i_sclk,
  input  wire logic              i_frame_sync,
  input  wire logic [CODE_W:0]   i_vin_pos,
  input  wire logic [CODE_W:0]   i_vin_neg,
  output logic                   o_sdo,
  output logic                   o_sdo_oe,
  output logic                   o_busy,
  output logic                   o_nap,
  output logic                   o_sampling,
  output logic                   o_powered_down,
  output logic                   o_ready,
  output logic                   o_result_invalid
);
  // ************************************************************
  // reset and synchronisers
  // ************************************************************
  // core logic is cleared straight from the pin, no clock needed
  wire core_rst_n = i_resetn & i_powerdown_reset_n;  // see RULE3

  logic [1:0] cs_q_r;
  logic [1:0] sclk_q_r;
  logic [1:0] fs_q_r;
  logic [1:0] pdr_q_r;
  logic       cs_d_r;
  logic       sclk_d_r;
  logic       fs_d_r;

  // two stages on the chip-select, serial clock, frame-sync and powerdown pins; only stage two is looked at
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cs_q_r   <= 2'h3;
      sclk_q_r <= 2'h3;  // serial clock idles high: no false rise
      fs_q_r   <= 2'h3;
      pdr_q_r  <= 2'h0;
    end else if (i_ce) begin
      cs_q_r   <= {cs_q_r[0], i_cs_n};
      sclk_q_r <= {sclk_q_r[0], i_sclk};
      fs_q_r   <= {fs_q_r[0], i_frame_sync};
      pdr_q_r  <= {pdr_q_r[0], i_powerdown_reset_n};
    end
  end

  // delayed copies for edge detection
  always_ff @(posedge i_mclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      cs_d_r   <= 1'b1;
      sclk_d_r <= 1'b1;
      fs_d_r   <= 1'b1;
    end else if (i_ce) begin
      cs_d_r   <= cs_q_r[1];
      sclk_d_r <= sclk_q_r[1];
      fs_d_r   <= fs_q_r[1];
    end
  end

  // ************************************************************
  // powerdown tracking
  // ************************************************************
  logic [11:0] pd_cnt_r;
  logic        pd_r;
  logic        pd_out_r;
  logic        waking_r;
  wire         pdr_s = pdr_q_r[1];

  // low time counter decides reset versus powerdown; wake delay
  // is counted only when leaving powerdown
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      pd_cnt_r <= 12'h000;
      pd_r     <= 1'b0;
      pd_out_r <= 1'b0;
      waking_r <= 1'b0;
    end else if (i_ce) begin
      pd_out_r <= pd_r;  // outside the core clear, see RULE8
      if (!pdr_s) begin
        waking_r <= 1'b0;
        if (pd_cnt_r >= PD_HOLD_CNT) begin
          pd_r <= 1'b1;  // see RULE8
        end else begin
          pd_cnt_r <= pd_cnt_r + 12'h001;
        end
      end else if (pd_r) begin
        pd_r     <= 1'b0;
        waking_r <= 1'b1;  // see RULE9
        pd_cnt_r <= 12'h001;
      end else if (waking_r) begin
        if (pd_cnt_r >= PD_WAKE_CNT) begin
          waking_r <= 1'b0;
          pd_cnt_r <= 12'h000;
        end else begin
          pd_cnt_r <= pd_cnt_r + 12'h001;
        end
      end else begin
        pd_cnt_r <= 12'h000;  // short reset: nothing to wait for, see RULE6
      end
    end
  end

  // ************************************************************
  // edge decode
  // ************************************************************
  wire cs_s      = cs_q_r[1];
  wire fs_s      = fs_q_r[1];
  wire sclk_rise = sclk_q_r[1] & ~sclk_d_r;
  wire sclk_fall = ~sclk_q_r[1] & sclk_d_r;
  wire cs_fall   = ~cs_s & cs_d_r;
  wire cs_rise   = cs_s & ~cs_d_r;
  wire fs_rise   = fs_s & ~fs_d_r;
  wire live      = pdr_s & ~waking_r & ~pd_r;
  // either framing style opens a frame (see RULE13)
  wire spi_start = cs_fall & fs_s;
  wire dsp_start = fs_rise & ~cs_s;
  wire start_ev  = live & (spi_start | dsp_start);

  // ************************************************************
  // frame state machine
  // ************************************************************
  sarc_state_e       state_r;
  sarc_state_e       state_nxt;
  logic [4:0]        rise_cnt_r;
  logic [4:0]        fall_cnt_r;
  logic [CODE_W-1:0] shift_r;
  logic [CODE_W-1:0] last_r;
  logic              aborted_r;
  logic              sdo_r;
  logic              sdo_oe_r;
  logic              nap_r;
  logic              samp_r;
  logic [2:0]        init_cnt_r;
  logic              invalid_r;

  wire               conv_done;
  wire [CODE_W-1:0]  conv_result;
  wire               in_conv   = (state_r == ST_CONV);
  wire               conv_kill = in_conv & start_ev;
  wire               end_samp  = (state_r == ST_SAMPLE) &
                                 ((sclk_fall &
                                   (fall_cnt_r == CONV_FALL - 5'h01))
                                  | cs_rise | fs_rise);
  wire               pre_abort = (state_r == ST_DATA) & (cs_rise | fs_rise);
  wire               to_samp   = (state_r == ST_DATA) & sclk_rise &
                                 (rise_cnt_r == SAMPLE_RISE - 5'h01);

  // input difference clipped to the code range (see RULE2)
  wire [CODE_W:0]    diff_raw  = i_vin_pos - i_vin_neg;
  wire               diff_neg  = i_vin_pos < i_vin_neg;
  wire [CODE_W-1:0]  diff_code = diff_neg ? CODE_ZERO
                                 : diff_raw[CODE_W] ? CODE_FULL
                                 : diff_raw[CODE_W-1:0];

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_ev) begin
          state_nxt = ST_DATA;
        end
      end
      ST_DATA: begin
        if (start_ev) begin
          state_nxt = ST_DATA;
        end else if (pre_abort) begin
          state_nxt = ST_IDLE;
        end else if (to_samp) begin
          state_nxt = ST_SAMPLE;  // see RULE14
        end
      end
      ST_SAMPLE: begin
        if (end_samp) begin
          state_nxt = ST_CONV;  // see RULE14
        end
      end
      ST_CONV: begin
        if (start_ev) begin
          state_nxt = ST_DATA;
        end else if (conv_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // state and edge counters; abort on reset is the async clear (see RULE4)
  always_ff @(posedge i_mclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      state_r    <= ST_IDLE;
      rise_cnt_r <= 5'h00;
      fall_cnt_r <= 5'h00;
    end else if (i_ce) begin
      state_r <= state_nxt;
      if (start_ev) begin
        rise_cnt_r <= 5'h00;
        fall_cnt_r <= 5'h00;
      end else begin
        if (sclk_rise & (rise_cnt_r != 5'h1F)) begin
          rise_cnt_r <= rise_cnt_r + 5'h01;
        end
        if (sclk_fall & (fall_cnt_r != 5'h1F)) begin
          fall_cnt_r <= fall_cnt_r + 5'h01;
        end
      end
    end
  end

  // serial data: msb at frame start, one bit per rise up to the last
  always_ff @(posedge i_mclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      shift_r   <= CODE_ZERO;
      last_r    <= CODE_ZERO;
      aborted_r <= 1'b0;
      sdo_r     <= 1'b0;
      sdo_oe_r  <= 1'b0;  // released while in reset, see RULE5
    end else if (i_ce) begin
      if (conv_done) begin
        last_r    <= conv_result;  // see RULE1
        aborted_r <= 1'b0;
      end
      if (conv_kill) begin
        aborted_r <= 1'b1;
      end
      if (start_ev) begin
        shift_r  <= (conv_kill | aborted_r) ? CODE_ABORT : last_r;
        sdo_r    <= (conv_kill | aborted_r) ? CODE_ABORT[CODE_W-1]
                    : last_r[CODE_W-1];
        sdo_oe_r <= 1'b1;
      end else begin
        if (sclk_rise & (rise_cnt_r < LAST_BIT_RISE - 5'h01)) begin
          shift_r <= shift_r << 1;
          sdo_r   <= shift_r[CODE_W-2];
        end
        if (cs_s) begin
          sdo_oe_r <= 1'b0;  // three-state with chip select high
        end
      end
    end
  end

  // nap, sampling switch and first-conversions flag
  always_ff @(posedge i_mclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      nap_r      <= 1'b0;
      samp_r     <= 1'b0;
      init_cnt_r <= 3'h0;
      invalid_r  <= 1'b1;  // see RULE15
    end else if (i_ce) begin
      if (conv_done) begin
        nap_r <= 1'b1;  // see RULE10
      end else if (sclk_rise & (rise_cnt_r == NAP_EXIT_RISE - 5'h01)) begin
        nap_r <= 1'b0;  // see RULE11
      end
      samp_r <= (state_nxt == ST_SAMPLE);  // see RULE12
      if (conv_done) begin
        invalid_r <= (init_cnt_r < INIT_CONVS);  // see RULE7
        if (init_cnt_r < INIT_CONVS) begin
          init_cnt_r <= init_cnt_r + 3'h1;
        end
      end
    end
  end

  // ************************************************************
  // conversion engine
  // ************************************************************
  sarc_approx sarc_approx_i (
    .i_mclk   (i_mclk),
    .i_rst_n  (core_rst_n),
    .i_ce     (i_ce),
    .i_start  (end_samp),
    .i_abort  (conv_kill),
    .i_held   (diff_code),
    .o_done   (conv_done),
    .o_result (conv_result)
  );

  // ************************************************************
  // outputs
  // ************************************************************
  logic busy_r;
  logic ready_r;

  // busy high from conversion start to end (see RULE13)
  always_ff @(posedge i_mclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      busy_r   <= 1'b0;
      ready_r  <= 1'b0;
    end else if (i_ce) begin
      busy_r   <= (state_nxt == ST_CONV);
      ready_r  <= live;
    end
  end

  assign o_sdo            = sdo_r;
  assign o_sdo_oe         = sdo_oe_r;
  assign o_busy           = busy_r;
  assign o_nap            = nap_r;
  assign o_sampling       = samp_r;
  assign o_powered_down   = pd_out_r;
  assign o_ready          = ready_r;
  assign o_result_invalid = invalid_r;
endmodule : sarc_ctrl
`default_nettype wire

// >>> verif/sarc_ctrl_asserts.sv
// checker on the ports of the converter control block
`timescale 1ns/1ps
`default_nettype none
module sarc_ctrl_asserts (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_powerdown_reset_n,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic o_sdo_oe,
  input wire logic o_busy,
  input wire logic o_nap,
  input wire logic o_sampling,
  input wire logic o_powered_down,
  input wire logic o_ready,
  input wire logic o_result_invalid
);
  // ************************************************************
  // helper: cycles the powerdown input has been seen low
  // ************************************************************
  logic [5:0] low_cnt_r;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) low_cnt_r <= 6'h00;
    else if (i_powerdown_reset_n) low_cnt_r <= 6'h00;
    else if (low_cnt_r != 6'h3F) low_cnt_r <= low_cnt_r + 6'h01;
  end

  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  property p_rst_tristate;
    !i_powerdown_reset_n |-> !o_sdo_oe;
  endproperty
  a_rst_tristate: assert property (p_rst_tristate)
    else $error("data driver on during reset");
  property p_rst_abort;
    !i_powerdown_reset_n |-> !o_busy;
  endproperty
  a_rst_abort: assert property (p_rst_abort)
    else $error("conversion kept during reset");
  property p_rst_invalid;
    !i_powerdown_reset_n |-> o_result_invalid;
  endproperty
  a_rst_invalid: assert property (p_rst_invalid)
    else $error("result not flagged invalid in reset");
  property p_pd_enter;
    low_cnt_r == 6'h1E |-> o_powered_down;
  endproperty
  a_pd_enter: assert property (p_pd_enter)
    else $error("long low did not power down");
  property p_pd_wake;
    $rose(i_powerdown_reset_n) && o_powered_down
      |-> !o_ready [*8] ##[1:40] o_ready;
  endproperty
  a_pd_wake: assert property (p_pd_wake)
    else $error("wake from powerdown out of window");
  property p_short_rst;
    $rose(i_powerdown_reset_n) && !o_powered_down |-> ##[0:8] o_ready;
  endproperty
  a_short_rst: assert property (p_short_rst)
    else $error("short reset did not resume");
  property p_conv_start;
    $fell(o_sampling) && i_powerdown_reset_n |-> o_busy;
  endproperty
  a_conv_start: assert property (p_conv_start)
    else $error("sampling ended without conversion");
  property p_nap_enter;
    $fell(o_busy) && i_powerdown_reset_n && i_cs_n |-> o_nap;
  endproperty
  a_nap_enter: assert property (p_nap_enter)
    else $error("no nap at end of conversion");
  property p_nap_exit;
    $fell(o_nap) && i_powerdown_reset_n |-> i_sclk && !i_cs_n;
  endproperty
  a_nap_exit: assert property (p_nap_exit)
    else $error("nap left off a serial clock rise");
  property p_sample_start;
    $rose(o_sampling) |-> i_sclk && !o_nap && !o_busy;
  endproperty
  a_sample_start: assert property (p_sample_start)
    else $error("sampling began off a clock rise");

  // main scenarios reached
  c_conv_end: cover property ($fell(o_busy));
  c_pd: cover property ($rose(o_powered_down));
  c_nap_exit: cover property ($fell(o_nap));
endmodule : sarc_ctrl_asserts

bind sarc_ctrl sarc_ctrl_asserts sarc_ctrl_asserts_i (
  .i_mclk(i_mclk), .i_resetn(i_resetn),
  .i_powerdown_reset_n(i_powerdown_reset_n), .i_cs_n(i_cs_n),
  .i_sclk(i_sclk), .o_sdo_oe(o_sdo_oe), .o_busy(o_busy), .o_nap(o_nap),
  .o_sampling(o_sampling), .o_powered_down(o_powered_down),
  .o_ready(o_ready), .o_result_invalid(o_result_invalid));
`default_nettype wire

// >>> verif/sarc_host_model.sv
// host serial port model: frames, clocks and collects one word
`timescale 1ns/1ps
`default_nettype none
module sarc_host_model (
  input  wire logic        i_mclk,
  input  wire logic        i_go,
  input  wire logic        i_dsp,
  input  wire logic [4:0]  i_falls,
  input  wire logic        i_nowait,
  input  wire logic        i_busy,
  input  wire logic        i_sdo_pin,
  output logic             o_cs_n,
  output logic             o_sclk,
  output logic             o_fs,
  output logic [13:0]      o_word,
  output logic             o_done
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;  // clock stands high between frames
    o_fs   = 1'b1;
    o_word = 14'h0000;
    o_done = 1'b0;
  end

  // half a serial clock period: 4 system clocks, 800 ns per bit
  task automatic half;
    repeat (4) @(posedge i_mclk);
  endtask : half

  // one frame per request; word bits taken at the first 14 falling edges
  always begin
    @(posedge i_mclk);
    if (i_go === 1'b1) begin
      o_done <= 1'b0;
      if (i_dsp) begin
        o_fs <= 1'b0;
        o_cs_n <= 1'b0;
        half();
        o_fs <= 1'b1;
        half();
        o_fs <= 1'b0;
        half();
      end else begin
        o_fs <= 1'b1;
        o_cs_n <= 1'b0;
        half();
      end
      for (int k = 1; k <= i_falls; k++) begin
        o_sclk <= 1'b0;
        if (k <= 14) o_word[14-k] <= i_sdo_pin;
        half();
        o_sclk <= 1'b1;
        half();
      end
      o_cs_n <= 1'b1;
      o_fs <= !i_dsp;
      // next frame only after the end of conversion (at most 80 clocks), or at once when i_nowait is set
      for (int n = 0; n < 80 && !i_nowait && i_busy !== 1'b0; n++)
        @(posedge i_mclk);
      o_done <= 1'b1;
    end
  end
endmodule : sarc_host_model
`default_nettype wire

// >>> verif/sar_adc_reset_nap_control_tb_top.sv
// testbench of the converter control block
`timescale 1ns/1ps
`default_nettype none
module sar_adc_reset_nap_control_tb_top
  import sarc_pkg::*;
;
  logic        mclk = 1'b0, resetn = 1'b0, ce = 1'b1, pwd_n = 1'b1;
  logic [14:0] vin_pos = 15'h0000, vin_neg = 15'h0000;
  logic        go = 1'b0, dsp = 1'b0, nowait = 1'b0;
  logic [4:0]  falls = 5'h10;
  wire logic   cs_n, sclk, fs, sdo, sdo_oe, busy, nap, sampling;
  wire logic   pdown, ready, invalid, done;
  wire logic [13:0] word;
  wire logic   sdo_pin = sdo_oe ? sdo : ~sdo;  // released line flips
  int miscompares = 0, samples_checked = 0;

  always #50 mclk = ~mclk;

  sarc_ctrl sarc_ctrl_i (.i_mclk(mclk), .i_resetn(resetn), .i_ce(ce),
    .i_powerdown_reset_n(pwd_n), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_frame_sync(fs), .i_vin_pos(vin_pos), .i_vin_neg(vin_neg),
    .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_busy(busy), .o_nap(nap),
    .o_sampling(sampling), .o_powered_down(pdown), .o_ready(ready),
    .o_result_invalid(invalid));
  sarc_host_model sarc_host_model_i (.i_mclk(mclk), .i_go(go),
    .i_dsp(dsp), .i_falls(falls), .i_nowait(nowait), .i_busy(busy),
    .i_sdo_pin(sdo_pin), .o_cs_n(cs_n), .o_sclk(sclk), .o_fs(fs),
    .o_word(word), .o_done(done));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task tally_and_finish;
    if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task chk(input logic [13:0] got, input logic [13:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task frame(input logic d, input logic [4:0] f, input logic nw);
    int n;
    n = 0;
    dsp <= d;
    falls <= f;
    nowait <= nw;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    while (done !== 1'b1 && n < 800) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 800) miscompares++;
  endtask : frame
  task wait_ready(output int n);
    n = 0;
    while (ready !== 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
  endtask : wait_ready

  // ************************************************************
  // scenarios
  // ************************************************************
  task t_codes;
    static logic [14:0] vp [6] = '{15'h400F, 15'h2000, 15'h2000, 15'h0000,
                            15'h0100, 15'h2ABC};
    static logic [14:0] vn [6] = '{15'h0000, 15'h0000, 15'h0001, 15'h0000,
                            15'h0200, 15'h0000};
    static logic [13:0] ex [6] = '{CODE_FULL, CODE_MID, 14'h1FFF, CODE_ZERO,
                            CODE_ZERO, 14'h2ABC};
    for (int i = 0; i < 7; i++) begin
      if (i < 6) begin
        vin_pos <= vp[i];
        vin_neg <= vn[i];
      end
      frame(i[0], 5'h10, 1'b0);
      if (i > 0) chk(word, ex[i-1]);
      chk({13'h0, invalid}, {13'h0, i < 4});
      chk({13'h0, nap}, 14'h0001);
    end
  endtask : t_codes
  task t_abort_early;
    frame(1'b0, 5'h04, 1'b0);
    repeat (6) @(posedge mclk);
    chk({13'h0, sdo_oe}, 14'h0000);
    chk({13'h0, sampling}, 14'h0000);
    frame(1'b0, 5'h10, 1'b0);
    chk(word, 14'h2ABC);
  endtask : t_abort_early
  task t_abort_conv;
    vin_pos <= 15'h1234;
    frame(1'b0, 5'h10, 1'b1);
    chk({13'h0, busy}, 14'h0001);
    frame(1'b0, 5'h10, 1'b0);
    chk(word, CODE_ABORT);
    frame(1'b1, 5'h10, 1'b0);
    chk(word, 14'h1234);
  endtask : t_abort_conv
  task t_short_reset;
    int n;
    frame(1'b0, 5'h10, 1'b1);
    chk({13'h0, busy}, 14'h0001);
    pwd_n <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({13'h0, busy}, 14'h0000);
    chk({13'h0, sdo_oe}, 14'h0000);
    chk({13'h0, invalid}, 14'h0001);
    pwd_n <= 1'b1;
    wait_ready(n);
    chk(14'(n < 10), 14'h0001);
    chk({13'h0, pdown}, 14'h0000);
  endtask : t_short_reset
  task t_powerdown;
    int n;
    pwd_n <= 1'b0;
    repeat (40) @(posedge mclk);
    chk({13'h0, pdown}, 14'h0001);
    pwd_n <= 1'b1;
    @(posedge mclk);
    wait_ready(n);  // host holds off frames until ready
    chk(14'(n >= 28 && n <= 40), 14'h0001);
    for (int i = 0; i < 5; i++) begin
      frame(i[0], 5'h10, 1'b0);
      chk({13'h0, invalid}, {13'h0, i < 4});
    end
  endtask : t_powerdown

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    int n;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    wait_ready(n);
    t_codes();
    t_abort_early();
    t_abort_conv();
    t_short_reset();
    t_powerdown();
    tally_and_finish();
  end
  initial begin
    #2000000;
    miscompares++;
    tally_and_finish();
  end
endmodule : sar_adc_reset_nap_control_tb_top
`default_nettype wire
